/* File: rtl/intensity_pkg.sv */
// package for the master / output-only port intensity block
// assumes a single 20 MHz clock and a simple register access port
package intensity_pkg;
  localparam logic [7:0] reg_master_and_port16_intensity = 8'h0E;
  localparam logic [7:0] intensity_reset = 8'h00;
  localparam int master_lsb = 4;
  localparam int port_lsb = 0;
  localparam logic [3:0] port_static = 4'hF;
  localparam logic [3:0] master_off = 4'h0;
  localparam logic [3:0] master_full = 4'hF;
  // oscillator tick period, cycles of clk per pwm slot
  localparam int clk_hz = 20_000_000;
  localparam int slot_hz = 1_000_000;
  localparam int slot_cycles = clk_hz / slot_hz;

  typedef struct packed {
    logic [3:0] master_level;
    logic [3:0] aux_port_level;
  } intensity_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

/* File: rtl/slot_divider.sv */
// slot tick divider: internal oscillator stand-in
// assumes clk and an active-low synchronous-released reset
`timescale 1ns/100ps
module slot_divider #(
  parameter int period = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  localparam int w = $clog2(period) + 1;
  logic [w-1:0] count;
  logic [w-1:0] next_count;

  initial begin
    if (period < 1) $error("period must be at least 1");
  end

  always_comb begin
    next_count = count;
    if (!run) begin
      // stopped oscillator clears its count and holds at zero
      next_count = '0;
    end else if (count == w'(period - 1)) begin
      next_count = '0;
    end else begin
      next_count = count + w'(1);
    end
  end

  assign tick = run && (count == w'(period - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

/* File: rtl/master_intensity_pwm_control.sv */
// master and output-only port intensity register with pwm generation
// assumes a serial bus front end that presents decoded byte accesses
//
// Behaviour
// - Register 0x0E holds master level in the upper nibble and port level in the lower.
// - Reading register 0x0E returns both stored nibbles unchanged.
// - Master level zero stops the oscillator and holds master_on and output_only_port low.
// - Master level n from 1 to 15 gives a master duty of n fifteenths.
// - Port level n from 0 to 14 gives a port duty of n plus one sixteenths.
// - Port level 15 makes the port follow the master output at full port duty.
`timescale 1ns/100ps
module master_intensity_pwm_control
  import intensity_pkg::*;
#(
  parameter int slot_period = intensity_pkg::slot_cycles
) (
  input wire logic clk,
  input wire logic nrst,
  input intensity_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  output intensity_pkg::intensity_s levels,
  output logic osc_running,
  output logic master_on,
  output logic output_only_port
);
  import intensity_pkg::*;

  // =====================================================
  // reset release
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  initial begin
    if (slot_period < 1) $error("slot_period must be at least 1");
  end

  // =====================================================
  // register
  intensity_s level_reg;
  intensity_s next_level_reg;
  logic [7:0] next_rdata;
  logic next_rvalid;

  function automatic logic hit(input logic [7:0] a);
    return a == reg_master_and_port16_intensity;
  endfunction

  always_comb begin
    next_level_reg = level_reg;
    next_rdata = 8'h00;
    next_rvalid = 1'b0;
    if (req.wr && hit(req.addr)) begin
      next_level_reg = intensity_s'(req.wdata);
    end
    if (req.rd) begin
      next_rvalid = 1'b1;
      next_rdata = hit(req.addr) ? 8'(level_reg) : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= intensity_s'(intensity_reset);
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      level_reg <= next_level_reg;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign levels = level_reg;

  // =====================================================
  // oscillator and pwm counters
  logic run;
  logic tick;
  assign run = level_reg.master_level != master_off;

  slot_divider #(
    .period(slot_period)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .tick(tick)
  );

  // master frame: 15 slots; port frame: 16 master frames' worth of sixteenths
  logic [3:0] mslot;
  logic [3:0] next_mslot;
  logic [3:0] pslot;
  logic [3:0] next_pslot;

  always_comb begin
    next_mslot = mslot;
    next_pslot = pslot;
    if (!run) begin
      next_mslot = 4'h0;
      next_pslot = 4'h0;
    end else if (tick) begin
      if (mslot == 4'hE) begin
        next_mslot = 4'h0;
        next_pslot = pslot + 4'h1;
      end else begin
        next_mslot = mslot + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mslot <= 4'h0;
      pslot <= 4'h0;
    end else begin
      mslot <= next_mslot;
      pslot <= next_pslot;
    end
  end

  // =====================================================
  // output decisions
  logic next_master_on;
  logic next_port;
  always_comb begin
    next_master_on = 1'b0;
    next_port = 1'b0;
    if (!run) begin
      next_master_on = 1'b0;
      next_port = 1'b0;
    end else begin
      next_master_on = mslot < level_reg.master_level;
      if (level_reg.aux_port_level == port_static) begin
        next_port = next_master_on;
      end else begin
        next_port = next_master_on && (pslot <= level_reg.aux_port_level);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_on <= 1'b0;
      output_only_port <= 1'b0;
      osc_running <= 1'b0;
    end else begin
      master_on <= next_master_on;
      output_only_port <= next_port;
      osc_running <= run;
    end
  end
endmodule

/* File: tb/pwm_assertions.sv */
// checker for the intensity block ports
// assumes decoded byte accesses and registered outputs
`timescale 1ns/100ps
module pwm_assertions (
  input wire logic clk,
  input wire logic nrst,
  input intensity_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input intensity_pkg::intensity_s levels,
  input wire logic osc_running,
  input wire logic master_on,
  input wire logic output_only_port
);
  import intensity_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wr_store_a: assert property (req.wr && req.addr == 8'h0E |=> levels == $past(req.wdata))
    else $error("store");
  rd_back_a: assert property (req.rd && !req.wr && req.addr == 8'h0E |=> rvalid && rdata == levels)
    else $error("readback");
  rvalid_cause_a: assert property (rvalid |-> $past(req.rd))
    else $error("rvalid");
  osc_state_a: assert property ($stable(levels) |-> osc_running == (levels[7:4] != 4'h0))
    else $error("osc");
  dark_off_a: assert property ($stable(levels) && levels[7:4] == 4'h0 |-> !(master_on || output_only_port))
    else $error("dark");
  master_full_a: assert property ($stable(levels) && levels[7:4] == 4'hF |-> master_on)
    else $error("full");
  port_static_a: assert property ($stable(levels) && levels == 8'hFF |-> output_only_port)
    else $error("static");
endmodule
bind master_intensity_pwm_control pwm_assertions i_pwm_assertions (.*);

/* File: tb/bus_host.sv */
// serial bus host stand-in issuing decoded byte accesses
// assumes requests are taken at the rising edge
`timescale 1ns/100ps
module bus_host (
  input wire logic clk,
  output intensity_pkg::reg_req_s req
);
  import intensity_pkg::*;
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{w, !w, a, d};
    @(posedge clk);
    // released lines show the inverse, never a stale value
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

/* File: tb/master_intensity_pwm_control_tb.sv */
// self-checking bench for the intensity block
// assumes the bus host model makes every access
`timescale 1ns/100ps
module master_intensity_pwm_control_tb;
  import intensity_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  reg_req_s req;
  logic [7:0] rdata, m, p;
  logic rvalid, osc_running, master_on, output_only_port;
  intensity_s levels;
  int fail_count = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  bus_host i_bus_host (.clk, .req);
  master_intensity_pwm_control #(.slot_period(1)) i_master_intensity_pwm_control (.clk,
    .nrst, .req, .rdata, .rvalid, .levels, .osc_running, .master_on, .output_only_port);
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    i_bus_host.acc(1'b0, a, 8'h00);
    #1 chk("rdata", e, rvalid ? rdata : 8'hXX);
  endtask
  task automatic t_regs();
    i_bus_host.acc(1'b1, 8'h0E, 8'hA5);
    #1 chk("levels", 8'hA5, levels);
    rd(8'h0E, 8'hA5);
    i_bus_host.acc(1'b1, 8'h0F, 8'h3C);
    rd(8'h0F, 8'h00);
    rd(8'h0E, 8'hA5);
    $display("regs done");
  endtask
  task automatic t_duty();
    logic [7:0] t [7] = '{8'h00, 8'h10, 8'h70, 8'hF0, 8'h3E, 8'hF7, 8'h5F};
    foreach (t[i]) begin
      i_bus_host.acc(1'b1, 8'h0E, t[i]);
      repeat (4) @(posedge clk);
      m = 0;
      p = 0;
      // 240 cycles is one whole port frame at slot_period 1
      repeat (240) begin
        @(posedge clk);
        // look after the edge so the registered outputs have settled
        #1;
        m += master_on;
        p += output_only_port;
      end
      chk("osc", {7'h0, t[i][7:4] != 0}, {7'h0, osc_running});
      chk("master", 8'(16 * int'(t[i][7:4])), m);
      chk("port", 8'(int'(t[i][7:4]) * (int'(t[i][3:0]) + 1)), p);
    end
    $display("duty done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_duty();
    wrap_up();
  end
endmodule
